// [core/sio_pkg.sv]
// constants for the servo digital i/o function mapper
// assumes one 250 MHz control clock and a 32-bit plain register port
package sio_pkg;
  // register byte offsets
  localparam logic [4:0] SIO_OFS_CTRL = 5'h00;
  localparam logic [4:0] SIO_OFS_FUNC = 5'h04;
  localparam logic [4:0] SIO_OFS_THR = 5'h08;
  localparam logic [4:0] SIO_OFS_RIPPLE = 5'h0C;
  localparam logic [4:0] SIO_OFS_TACH = 5'h10;
  localparam logic [4:0] SIO_OFS_STAT = 5'h14;
  localparam logic [4:0] SIO_OFS_MASK = 5'h18;
  localparam logic [4:0] SIO_OFS_INFO = 5'h1C;
  // ctrl fields: gp levels [5:0], fast pair bit 8, tach select bit 9
  localparam int SIO_CTRL_FAST_BIT = 8;
  localparam int SIO_CTRL_TACH_BIT = 9;
  // status bits
  localparam int SIO_ST_ALARM = 0;
  localparam int SIO_ST_CONFLICT = 1;
  localparam int SIO_ST_STEP_FAST = 2;
  localparam int SIO_ST_HS_FAST = 3;
  localparam int SIO_ST_W = 4;
  // reset values
  localparam logic [31:0] SIO_CTRL_RST = 32'h0000_0000;
  localparam logic [5:0] SIO_FUNC_RST = 6'h00;
  localparam logic [31:0] SIO_THR_RST = 32'h0010_0010;
  localparam logic [15:0] SIO_RIPPLE_RST = 16'h0008;
  localparam logic [15:0] SIO_TACH_RST = 16'h0001;
  localparam logic [3:0] SIO_MASK_RST = 4'h0;
  // control modes
  localparam logic [1:0] SIO_MODE_POS = 2'h0;
  localparam logic [1:0] SIO_MODE_VEL = 2'h1;
  localparam logic [1:0] SIO_MODE_TRQ = 2'h2;
  localparam logic [1:0] SIO_MODE_CSPD = 2'h3;
  // timing
  localparam int SIO_CLK_NS = 4;
  localparam int SIO_STEP_MAX_KHZ = 500;
  localparam int SIO_HS_MAX_KHZ = 2000;
  localparam int SIO_STEP_MIN_NS = 1000000 / SIO_STEP_MAX_KHZ;
  localparam int SIO_HS_MIN_NS = 1000000 / SIO_HS_MAX_KHZ;
  localparam logic [9:0] SIO_STEP_MIN_CYC =
    10'((SIO_STEP_MIN_NS + SIO_CLK_NS - 1) / SIO_CLK_NS);
  localparam logic [9:0] SIO_HS_MIN_CYC =
    10'((SIO_HS_MIN_NS + SIO_CLK_NS - 1) / SIO_CLK_NS);
endpackage : sio_pkg

// [core/sio_mapper.sv]
// servo digital i/o function mapper: pulse inputs, discrete input
// functions, six programmable status outputs, tach out, interrupt
// assumes drive status inputs on clk; pins are asynchronous
//
// Summary of operation
// [RULE1] six outputs, function or general purpose each
// [RULE2] each channel has its own function select
// [RULE3] channel two drives brake when selected
// [RULE4] moving asserts when dynamic error below threshold
// [RULE5] velocity reached: speed equal, ripple in range
// [RULE6] ready only when controllable and no alarm
// [RULE7] in position: target reached, error below threshold
// [RULE8] channel six emits tach pulses, configurable rate
// [RULE9] two pulse pairs: step/dir and fast
// [RULE10] host uses only one pulse pair
// [RULE11] step/dir pair accepts up to 500 kHz
// [RULE12] fast pair accepts up to 2 MHz
// [RULE13] ninth input selects encoder resolution, all modes
// [RULE14] inhibit input drops pulses in position mode
// [RULE15] inputs ten to twelve give speed code
// [RULE16] input three enables servo, four clears alarm
// [RULE17] mode-specific outputs low in other modes
//
// Decided for this implementation: the strobed register port and the register addresses.
`timescale 1ns/1ps
module sio_mapper
  import sio_pkg::*;
#(
  parameter int ERR_W = 16
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  // pulse pins
  input wire logic step_line,
  input wire logic dir_line,
  input wire logic fast_pulse_line,
  input wire logic fast_sign_line,
  // discrete input pins
  input wire logic in_servo_enable,
  input wire logic in_alarm_clear,
  input wire logic in_resolution_select,
  input wire logic in_pulse_inhibit,
  input wire logic in_speed_sel2,
  input wire logic in_speed_sel3,
  // drive status
  input wire logic [1:0] ctrl_mode,
  input wire logic drive_able,
  input wire logic alarm_event,
  input wire logic brake_engage,
  input wire logic torque_reached,
  input wire logic target_reached,
  input wire logic [ERR_W-1:0] pos_error,
  input wire logic [ERR_W-1:0] dyn_error,
  input wire logic [ERR_W-1:0] speed_meas,
  input wire logic [ERR_W-1:0] speed_target,
  input wire logic [ERR_W-1:0] speed_ripple,
  input wire logic enc_tick,
  // command results
  output logic cmd_pulse,
  output logic cmd_dir,
  output logic servo_on,
  output logic resolution_alt,
  output logic [2:0] speed_code,
  // status output channels
  output logic out_ch_alarm,
  output logic out_ch_brake,
  output logic out_ch_torque_reached,
  output logic out_ch_motion_velocity,
  output logic out_ch_ready,
  output logic out_ch_inpos_tach,
  // interrupt
  output logic irq
);

////////////////////////////////////////////////////////////////////////
  logic [9:0] pin_a;
  logic [9:0] pin_m_q;
  logic [9:0] pin_s_q;
  logic [9:0] pin_p_q;

  assign pin_a = {in_speed_sel3, in_speed_sel2, in_pulse_inhibit,
                  in_resolution_select, in_alarm_clear, in_servo_enable,
                  fast_sign_line, fast_pulse_line, dir_line, step_line};

  // two-stage synchroniser per pin, plus a history stage for edges
  for (genvar i = 0; i < 10; i++)
  begin : g_sync
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
      begin
        pin_m_q[i] <= 1'b0;
        pin_s_q[i] <= 1'b0;
        pin_p_q[i] <= 1'b0;
      end
      else if (ce)
      begin
        pin_m_q[i] <= pin_a[i];
        pin_s_q[i] <= pin_m_q[i];
        pin_p_q[i] <= pin_s_q[i];
      end
    end
  end

////////////////////////////////////////////////////////////////////////
  logic [31:0] ctrl_q;
  logic [5:0] func_q;
  logic [31:0] thr_q;
  logic [15:0] ripple_q;
  logic [15:0] tach_q;
  logic [SIO_ST_W-1:0] stat_q;
  logic [SIO_ST_W-1:0] mask_q;
  logic [SIO_ST_W-1:0] ev;
  logic [5:0] out_q;
  logic alarm_q;
  logic fast_sel;

  assign fast_sel = ctrl_q[SIO_CTRL_FAST_BIT];

  // software-written configuration
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= SIO_CTRL_RST;
      func_q <= SIO_FUNC_RST;
      thr_q <= SIO_THR_RST;
      ripple_q <= SIO_RIPPLE_RST;
      tach_q <= SIO_TACH_RST;
      mask_q <= SIO_MASK_RST;
    end
    else if (ce && reg_we)
    begin
      case (reg_addr)
        SIO_OFS_CTRL: ctrl_q <= reg_wdata;
        SIO_OFS_FUNC: func_q <= reg_wdata[5:0]; // [RULE2]
        SIO_OFS_THR: thr_q <= reg_wdata;
        SIO_OFS_RIPPLE: ripple_q <= reg_wdata[15:0];
        SIO_OFS_TACH: tach_q <= reg_wdata[15:0];
        SIO_OFS_MASK: mask_q <= reg_wdata[SIO_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // sticky status: a new event wins over a write-one clear
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      stat_q <= '0;
    else if (ce)
    begin
      if (reg_we && reg_addr == SIO_OFS_STAT)
        stat_q <= (stat_q & ~reg_wdata[SIO_ST_W-1:0]) | ev;
      else
        stat_q <= stat_q | ev;
    end
  end

  // read data valid the cycle after the strobe only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      reg_rdata <= '0;
    else if (ce)
    begin
      reg_rdata <= '0;
      if (reg_re)
        case (reg_addr)
          SIO_OFS_CTRL: reg_rdata <= ctrl_q;
          SIO_OFS_FUNC: reg_rdata <= {26'h0, func_q};
          SIO_OFS_THR: reg_rdata <= thr_q;
          SIO_OFS_RIPPLE: reg_rdata <= {16'h0, ripple_q};
          SIO_OFS_TACH: reg_rdata <= {16'h0, tach_q};
          SIO_OFS_STAT: reg_rdata <= {28'h0, stat_q};
          SIO_OFS_MASK: reg_rdata <= {28'h0, mask_q};
          SIO_OFS_INFO: reg_rdata <= {22'h0, alarm_q, servo_on, 2'h0,
                                      out_q};
          default: reg_rdata <= '0;
        endcase
    end
  end

  // level interrupt from unmasked sticky bits
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      irq <= 1'b0;
    else if (ce)
      irq <= |(stat_q & mask_q);
  end

////////////////////////////////////////////////////////////////////////
  logic step_rise;
  logic hs_rise;
  logic clr_rise;
  logic [9:0] step_gap_q;
  logic [9:0] hs_gap_q;
  logic pos_mode;

  assign pos_mode = ctrl_mode == SIO_MODE_POS;
  assign step_rise = pin_s_q[0] & ~pin_p_q[0];
  assign hs_rise = pin_s_q[2] & ~pin_p_q[2];
  assign clr_rise = pin_s_q[5] & ~pin_p_q[5];
  // pulse on the idle pair means the host drove both
  assign ev[SIO_ST_CONFLICT] = fast_sel ? step_rise : hs_rise; // [RULE10]
  assign ev[SIO_ST_STEP_FAST] = step_rise &&
    step_gap_q < SIO_STEP_MIN_CYC; // [RULE11]
  assign ev[SIO_ST_HS_FAST] = hs_rise &&
    hs_gap_q < SIO_HS_MIN_CYC; // [RULE12]
  assign ev[SIO_ST_ALARM] = alarm_event;

  // saturating gaps since the last edge of each pair
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      step_gap_q <= '1;
      hs_gap_q <= '1;
    end
    else if (ce)
    begin
      step_gap_q <= step_rise ? 10'h000 :
        step_gap_q + {9'h000, step_gap_q != 10'h3FF};
      hs_gap_q <= hs_rise ? 10'h000 :
        hs_gap_q + {9'h000, hs_gap_q != 10'h3FF};
    end
  end

  // command pulse from the selected pair only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_pulse <= 1'b0;
      cmd_dir <= 1'b0;
    end
    else if (ce)
    begin
      cmd_pulse <= pos_mode && !pin_s_q[7] && // [RULE14]
        (fast_sel ? hs_rise : step_rise); // [RULE9]
      cmd_dir <= fast_sel ? pin_s_q[3] : pin_s_q[1];
    end
  end

  // discrete input functions
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      servo_on <= 1'b0;
      resolution_alt <= 1'b0;
      speed_code <= 3'h0;
    end
    else if (ce)
    begin
      servo_on <= pin_s_q[4]; // [RULE16]
      resolution_alt <= pin_s_q[6]; // [RULE13]
      // code held at zero outside changed-speed mode
      speed_code <= (ctrl_mode == SIO_MODE_CSPD) ?
        pin_s_q[9:7] : 3'h0; // [RULE15]
    end
  end

  // latched alarm; a new fault beats a clear in the same cycle
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      alarm_q <= 1'b0;
    else if (ce)
    begin
      if (alarm_event)
        alarm_q <= 1'b1;
      else if (clr_rise)
        alarm_q <= 1'b0; // [RULE16]
    end
  end

////////////////////////////////////////////////////////////////////////
  logic [15:0] tach_cnt_q;
  logic tach_q_out;
  logic [5:0] fn;
  logic vel_mode;

  assign vel_mode = ctrl_mode == SIO_MODE_VEL ||
    ctrl_mode == SIO_MODE_TRQ;

  // divide encoder ticks; toggling halves the rate but keeps duty even
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tach_cnt_q <= 16'h0000;
      tach_q_out <= 1'b0;
    end
    else if (ce && enc_tick)
    begin
      if (tach_cnt_q + 16'h0001 >= tach_q)
      begin
        tach_cnt_q <= 16'h0000;
        tach_q_out <= ~tach_q_out; // [RULE8]
      end
      else
        tach_cnt_q <= tach_cnt_q + 16'h0001;
    end
  end

  // per-channel function value
  always_comb
  begin
    fn[0] = alarm_q;
    fn[1] = brake_engage; // [RULE3]
    fn[2] = torque_reached;
    fn[3] = pos_mode ? dyn_error < thr_q[31:16] : // [RULE4]
      vel_mode && speed_meas == speed_target &&
      speed_ripple <= ripple_q; // [RULE5] [RULE17]
    fn[4] = drive_able && !alarm_q; // [RULE6]
    // tach when the ctrl tach bit is set, else in-position
    fn[5] = ctrl_q[SIO_CTRL_TACH_BIT] ? tach_q_out :
      pos_mode && target_reached &&
      pos_error < thr_q[15:0]; // [RULE7] [RULE17]
  end

  // each channel: its function or the general purpose level
  for (genvar c = 0; c < 6; c++)
  begin : g_out
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        out_q[c] <= 1'b0;
      else if (ce)
        out_q[c] <= func_q[c] ? fn[c] : ctrl_q[c]; // [RULE1]
    end
  end

  assign out_ch_alarm = out_q[0];
  assign out_ch_brake = out_q[1];
  assign out_ch_torque_reached = out_q[2];
  assign out_ch_motion_velocity = out_q[3];
  assign out_ch_ready = out_q[4];
  assign out_ch_inpos_tach = out_q[5];

////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ready_alarm_a: assert property ( // [RULE6]
    ce && func_q[4] && alarm_q |=> !out_ch_ready)
    else $error("ready high during alarm");
  brake_follow_a: assert property ( // [RULE3]
    ce && func_q[1] |=> out_ch_brake == $past(brake_engage))
    else $error("brake channel not following request");
  inhibit_drop_a: assert property ( // [RULE14]
    ce && pin_s_q[7] |=> !cmd_pulse)
    else $error("pulse passed while inhibited");
  mode_gate_a: assert property ( // [RULE17]
    ce && func_q[5] && !ctrl_q[SIO_CTRL_TACH_BIT] && !pos_mode
    |=> !out_ch_inpos_tach)
    else $error("in-position high outside position mode");
  velocity_gate_a: assert property ( // [RULE5]
    ce && func_q[3] && vel_mode && speed_meas != speed_target
    |=> !out_ch_motion_velocity)
    else $error("velocity reached with speed mismatch");
  pulse_pair_a: assert property ( // [RULE9]
    ce && fast_sel && step_rise && !hs_rise |=> !cmd_pulse)
    else $error("pulse taken from idle pair");
  step_rate_a: assert property ( // [RULE11]
    ce && step_rise && step_gap_q < SIO_STEP_MIN_CYC
    |=> stat_q[SIO_ST_STEP_FAST])
    else $error("fast step rate not flagged");
  alarm_clear_a: assert property ( // [RULE16]
    ce && clr_rise && !alarm_event |=> !alarm_q)
    else $error("alarm not cleared");
  gp_level_a: assert property ( // [RULE1]
    ce && !func_q[0] |=> out_ch_alarm == $past(ctrl_q[0]))
    else $error("general purpose level wrong");

  pulse_cov: cover property (ce && cmd_pulse);
  conflict_cov: cover property (ce && ev[SIO_ST_CONFLICT]);
  tach_cov: cover property (ce && enc_tick && tach_cnt_q == 16'h0000);
  irq_cov: cover property (irq);

endmodule : sio_mapper

// [verification/sio_host_model.sv]
// host pulse source model driving the two pulse command pairs
// assumes the mapper's clock; fire is a one-cycle request while idle
`timescale 1ns/1ps
module sio_host_model
#(
  parameter int STEP_CYC = 500,
  parameter int FAST_CYC = 125
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // request
  input wire logic fire,
  input wire logic fast,
  input wire logic dir,
  output logic busy,
  // pulse pins
  output logic step_line,
  output logic dir_line,
  output logic fast_pulse_line,
  output logic fast_sign_line
);
  logic [9:0] cnt_q;
  logic fast_q;
  logic [9:0] per;
  logic hi;
  // period at the top rate of the pair in use, never shorter
  assign per = fast_q ? 10'(FAST_CYC) : 10'(STEP_CYC);
  // direction settles five cycles before the pulse line rises
  assign hi = busy && cnt_q >= 10'h4 && cnt_q < 10'h4 + (per >> 1);
  //////////////////////////////////////////////////////////////////////
  // one pulse per request, direction held for the whole pulse
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy <= 1'h0;
      cnt_q <= 10'h0;
      fast_q <= 1'h0;
      dir_line <= 1'h0;
      fast_sign_line <= 1'h0;
    end
    else if (fire && !busy)
    begin
      busy <= 1'h1;
      cnt_q <= 10'h0;
      fast_q <= fast;
      if (fast)
        fast_sign_line <= dir;
      else
        dir_line <= dir;
    end
    else if (busy)
    begin
      cnt_q <= cnt_q + 10'h1;
      busy <= cnt_q != per + 10'h4;
    end
  end
  // only the chosen pair ever pulses, the other stays low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      step_line <= 1'h0;
      fast_pulse_line <= 1'h0;
    end
    else
    begin
      step_line <= hi && !fast_q;
      fast_pulse_line <= hi && fast_q;
    end
  end
endmodule : sio_host_model

// [verification/testbench.sv]
// self-checking bench for the i/o mapper beside a host pulse model
// assumes sio_mapper and sio_host_model are compiled before it
`timescale 1ns/1ps
module testbench;
  import sio_pkg::*;
  logic clk = '0, rst = '1, ce = '1, reg_we = '0, reg_re = '0, fire = '0;
  logic fast = '0, dir = '0, busy, in_servo_enable = '0, in_alarm_clear = '0;
  logic in_resolution_select = '0, in_pulse_inhibit = '0, in_speed_sel2 = '0;
  logic in_speed_sel3 = '0, drive_able = '0, alarm_event = '0, enc_tick = '0;
  logic brake_engage = '0, torque_reached = '0, target_reached = '0, irq;
  logic [4:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0, reg_rdata, s = 32'h806F;
  logic [1:0] ctrl_mode = '0;
  logic [15:0] pos_error = '0, dyn_error = '0, speed_meas = '0;
  logic [15:0] speed_target = '0, speed_ripple = '0;
  logic step_line, dir_line, fast_pulse_line, fast_sign_line, cmd_pulse;
  logic cmd_dir, servo_on, resolution_alt, out_ch_alarm, out_ch_brake;
  logic out_ch_torque_reached, out_ch_motion_velocity, out_ch_ready;
  logic out_ch_inpos_tach, rd_seen = '0;
  logic [2:0] speed_code;
  logic [5:0] ch, t;
  logic [31:0] rd_q[$];
  logic dir_q[$];
  int n_fail = 0, total_checks = 0, cyc = 0, k;
  sio_mapper sio_mapper_inst (.*);
  sio_host_model sio_host_model_inst (.*);
  assign ch = {out_ch_inpos_tach, out_ch_ready, out_ch_motion_velocity,
    out_ch_torque_reached, out_ch_brake, out_ch_alarm};
  always #2 clk = ~clk;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // channel levels with every function selected and no alarm
  function automatic logic [5:0] exp_ch(input logic [31:0] v);
    logic mv;
    mv = v[1:0] == SIO_MODE_POS ? v[17:13] < SIO_THR_RST[31:16] :
      v[1:0] == SIO_MODE_CSPD ? 1'h0 :
      v[19:18] == v[21:20] && v[25:22] <= SIO_RIPPLE_RST;
    return {v[1:0] == SIO_MODE_POS && v[5] && v[12:8] < SIO_THR_RST[15:0],
      v[2], mv, v[4], v[3], 1'h0};
  endfunction : exp_ch
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wt
  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_we <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'h0;
  endtask : wr
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clk);
    reg_re <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'h0;
  endtask : rd
  task automatic pulse(input logic f, d, ok);
    int i;
    if (ok)
      dir_q.push_back(d);
    @(posedge clk);
    fire <= 1'h1;
    fast <= f;
    dir <= d;
    wt(1);
    fire <= 1'h0;
    for (i = 0; i < 1000 && busy === 1'h1; i++)
      @(posedge clk);
    wt(8);
  endtask : pulse
  //////////////////////////////////////////////////////////////////////
  // results are matched against the oldest note as they appear
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      print_verdict();
    end
    if (rd_seen)
      chk("reg_rdata", rd_q.pop_front(), reg_rdata);
    if (cmd_pulse === 1'h1)
    begin
      if (dir_q.size() == 0)
        chk("cmd_pulse", 32'h0, 32'h1);
      else
        chk("cmd_dir", 32'(dir_q.pop_front()), 32'(cmd_dir));
    end
    rd_seen <= reg_re;
  end
  initial
  begin
    wt(10);
    chk("outputs", 32'h0, {ch, irq, cmd_pulse, servo_on});
    rst <= 1'h0;
    rd(SIO_OFS_THR, SIO_THR_RST);
    rd(SIO_OFS_RIPPLE, 32'(SIO_RIPPLE_RST));
    rd(SIO_OFS_TACH, 32'(SIO_TACH_RST));
    rd(SIO_OFS_FUNC, 32'(SIO_FUNC_RST));
    rd(5'h03, 32'h0);
    s = lfsr(s);
    wr(SIO_OFS_CTRL, 32'(s[5:0]));
    wt(3);
    chk("gp channels", 32'(s[5:0]), 32'(ch));
    wr(SIO_OFS_FUNC, 32'h3F);
    wr(SIO_OFS_CTRL, 32'h0);
    for (k = 0; k < 24; k++)
    begin
      s = lfsr(s);
      {ctrl_mode, drive_able, brake_engage} <= {s[1:0], s[2], s[3]};
      {target_reached, torque_reached} <= s[5:4];
      {pos_error, dyn_error} <= {16'(s[12:8]), 16'(s[17:13])};
      {speed_meas, speed_target} <= {16'(s[19:18]), 16'(s[21:20])};
      speed_ripple <= 16'(s[25:22]);
      {in_resolution_select, in_servo_enable} <= s[27:26];
      {in_speed_sel3, in_speed_sel2, in_pulse_inhibit} <= s[30:28];
      wt(6);
      chk("channels", 32'(exp_ch(s)), 32'(ch));
      chk("servo_on", 32'(s[26]), 32'(servo_on));
      chk("resolution", 32'(s[27]), 32'(resolution_alt));
      chk("speed_code", s[1:0] == 2'h3 ? 32'(s[30:28]) : 32'h0,
        32'(speed_code));
    end
    {ctrl_mode, drive_able, in_pulse_inhibit} <= 4'h2;
    alarm_event <= 1'h1;
    wt(1);
    alarm_event <= 1'h0;
    wt(3);
    chk("irq masked", 32'h0, 32'(irq));
    chk("alarm ready", 32'h1, {ch[4], ch[0]});
    wr(SIO_OFS_MASK, 32'h1);
    wt(3);
    chk("irq", 32'h1, 32'(irq));
    rd(SIO_OFS_STAT, 32'h1);
    wr(SIO_OFS_STAT, 32'h1);
    wt(3);
    // status cleared, but the alarm latch only drops on the clear input
    chk("irq cleared", 32'h1, {irq, ch[4], ch[0]});
    in_alarm_clear <= 1'h1;
    wt(6);
    chk("alarm cleared", 32'h2, {ch[4], ch[0]});
    wr(SIO_OFS_CTRL, 32'h200);
    // let channel six settle on the tach source before sampling it
    wt(2);
    for (k = 0; k < 3; k++)
    begin
      t = ch;
      enc_tick <= 1'h1;
      wt(1);
      enc_tick <= 1'h0;
      wt(3);
      chk("tach", 32'(!t[5]), 32'(ch[5]));
    end
    wr(SIO_OFS_CTRL, 32'h0);
    pulse(1'h0, 1'h1, 1'h1);
    pulse(1'h0, 1'h0, 1'h1);
    wr(SIO_OFS_CTRL, 32'h100);
    pulse(1'h1, 1'h1, 1'h1);
    pulse(1'h1, 1'h0, 1'h1);
    rd(SIO_OFS_STAT, 32'h0);
    pulse(1'h0, 1'h1, 1'h0);
    rd(SIO_OFS_STAT, 32'h2);
    wr(SIO_OFS_STAT, 32'hF);
    wr(SIO_OFS_CTRL, 32'h0);
    in_pulse_inhibit <= 1'h1;
    wt(4);
    pulse(1'h0, 1'h1, 1'h0);
    {in_pulse_inhibit, ctrl_mode} <= 3'h1;
    pulse(1'h0, 1'h0, 1'h0);
    chk("pending pulses", 32'h0, 32'(dir_q.size()));
    print_verdict();
  end
endmodule : testbench
